// file: bench/rbt_legal_model.sv
// far side model: external command legality logic
module rbt_legal_model (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_start,
  input  wire logic [11:0] i_command_vector,
  input  wire logic        i_veto,
  input  wire logic [9:0]  i_delay,
  output logic             o_command_accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt_r;
  logic       legal;

  always_ff @(posedge i_clk) begin
    if (i_srst || i_start) begin
      cnt_r <= 10'h000;
    end else if (cnt_r != 10'h3FF) begin
      cnt_r <= cnt_r + 10'h001;
    end
  end
  // broadcast transmit never legal; the bench may veto any other command
  assign legal = !i_veto && !(i_command_vector[11] && i_command_vector[10]);
  // bench keeps i_delay under 375 cycles, so the answer always beats 3 us
  assign o_command_accepted = !i_srst && legal && (cnt_r >= i_delay);
endmodule

// file: bench/testbench.sv
// self-checking testbench for the built-in-test word and command legality
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OVR = 20;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        ce = 1'b1;
  logic        i_bit_cmd_bus = 1'b0;
  logic        i_error_clear_in = 1'b0;
  logic [1:0]  txa = 2'h0;
  logic [11:0] pv = 12'h000;
  logic [15:0] i_cmd_word = 16'h0;
  logic        veto = 1'b0;
  logic [9:0]  dly = 10'h0;
  logic        acc;
  logic [31:0] o_rdata;
  logic [11:0] o_command_vector;
  logic [15:0] o_bit_word;
  logic [1:0]  o_bus_disabled;
  logic        o_message_error_flag;
  logic        o_status_tx_req;
  logic        o_msg_fail_irq;
  logic [15:0] exp;
  logic [31:0] d;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          pos[6] = '{13, 14, 9, 8, 7, 5};
  logic [15:0] cw[6] = '{16'h0C21, 16'h0000, 16'hFBFF, 16'h5555, 16'hFC44, 16'h0C44};
  logic        cv[6] = '{0, 1, 0, 1, 0, 0};
  int          cd[6] = '{0, 0, 300, 0, 0, 0};
  logic        ci[6] = '{0, 1, 0, 1, 1, 0};

  rbt_bit_core #(.OVERRUN_CYC(OVR)) u_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bit_cmd(pv[10]),
    .i_bit_cmd_bus(i_bit_cmd_bus), .i_loopback_fault(pv[1:0]),
    .i_word_count_fault(pv[2]), .i_manchester_fault(pv[3]), .i_parity_fault(pv[4]),
    .i_backend_timeout_fault(pv[5]), .i_error_clear_in(i_error_clear_in),
    .i_tx_active(txa), .i_shutdown_mc(pv[7:6]), .i_reenable_mc(pv[9:8]),
    .i_cmd_stb(pv[11]), .i_cmd_word(i_cmd_word), .i_command_accepted(acc),
    .o_command_vector(o_command_vector), .o_bit_word(o_bit_word),
    .o_bus_disabled(o_bus_disabled), .o_message_error_flag(o_message_error_flag),
    .o_status_tx_req(o_status_tx_req), .o_msg_fail_irq(o_msg_fail_irq));

  rbt_legal_model u_far (
    .i_clk(i_clk), .i_srst(i_srst), .i_start(pv[11]), .i_command_vector(o_command_vector),
    .i_veto(veto), .i_delay(dly), .o_command_accepted(acc));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: whole run needs about 2650 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // waits, then samples the word away from the clock edge
  task automatic word(input int n);
    cyc(n);
    @(negedge i_clk);
    chk("bit word", o_bit_word, exp);
  endtask

  task automatic pulse(input logic [11:0] m);
    @(posedge i_clk);
    pv <= m;
    @(posedge i_clk);
    pv <= 12'h000;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask

  task automatic cmd(input int k);
    int np;
    int ns;
    logic [11:0] ev;
    np = 0;
    ns = 0;
    ev = {cw[k][15:11] == 5'h1F, cw[k][10], cw[k][9:5], cw[k][4:0]};
    @(posedge i_clk);
    i_cmd_word <= cw[k];
    veto <= cv[k];
    dly <= 10'(cd[k]);
    pulse(12'h800);
    // verdict lands by 375 waiting cycles; count the one-cycle pulses
    repeat (400) begin
      @(negedge i_clk);
      ns += int'(o_status_tx_req === 1'b1);
      np += int'(o_msg_fail_irq === 1'b1);
    end
    chk("vector", o_command_vector, ev);
    chk("message error", o_message_error_flag, ci[k]);
    chk("status request", ns, ci[k]);
    chk("failure irq", np, ci[k]);
    rd(4'h8);
    chk("cmd reg", d, {17'h00000, 1'b0, ci[k], !ci[k], ev});
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    cyc(16);
    i_srst <= 1'b0;
    exp = {11'h000, rbt_pkg::CORE_VERSION};
    word(0);
    rd(4'h4);
    chk("ctrl", d, 32'h2);
    rd(4'hC);
    chk("unmapped", d, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      pulse(12'h001 << i);
      exp[pos[i]] = 1'b1;
      word(3);
    end
    word(20);
    rd(4'h0);
    chk("bit read", d, {16'h0, exp});
    @(posedge i_clk);
    i_error_clear_in <= 1'b1;
    cyc(10);
    i_error_clear_in <= 1'b0;
    exp = {11'h000, rbt_pkg::CORE_VERSION};
    word(4);
    pulse(12'h010);
    exp[7] = 1'b1;
    word(3);
    wr(4'h4, 32'h6);
    exp[7] = 1'b0;
    word(3);
    rd(4'h4);
    chk("ctrl", d, 32'h2);
    // a fault pulse while the enable is low must be lost
    @(posedge i_clk);
    ce <= 1'b0;
    pulse(12'h010);
    @(posedge i_clk);
    ce <= 1'b1;
    word(3);
    $display("test faults done");
    for (int b = 1; b >= 0; b--) begin
      @(posedge i_clk);
      i_bit_cmd_bus <= b[0];
      pulse(12'h400);
      exp[15] = b[0];
      word(3);
    end
    wr(4'h4, 32'h3);
    exp[10] = 1'b1;
    word(3);
    wr(4'h4, 32'h2);
    exp[10] = 1'b0;
    word(3);
    $display("test bus and inhibit done");
    for (int b = 0; b < 2; b++) begin
      pulse(12'h040 << b);
      exp[11 + b] = 1'b1;
      word(3);
      chk("bus disabled", o_bus_disabled, exp[12:11]);
      pulse(12'h100 << b);
      exp[11 + b] = 1'b0;
      word(3);
      @(posedge i_clk);
      txa[b] <= 1'b1;
      word(OVR + 1);
      exp[11 + b] = 1'b1;
      word(1);
      chk("bus disabled", o_bus_disabled, exp[12:11]);
      @(posedge i_clk);
      txa[b] <= 1'b0;
      pulse(12'h100 << b);
      exp[11 + b] = 1'b0;
      word(3);
    end
    $display("test shutdown done");
    for (int k = 0; k < 6; k++) begin
      if (k == 4) begin
        wr(4'h4, 32'h0);
      end
      cmd(k);
    end
    $display("test legality done");
    conclude();
  end
endmodule

// file: src/rbt_bit_core.sv
// built-in-test word, error flags and command legality for the remote terminal
// ----------------------------------------
// Functional notes
// - bit 15 shows the bus the transmit BIT command came on, 1 = B
// - bit 14 sets on bus B loopback fault, clears only on error clear
// - bit 13 sets on bus A loopback fault, clears only on error clear
// - bit 12 marks bus B off after shutdown code or 668 us transmit
// - bit 11 marks bus A off after shutdown code or overrun timer
// - bit 10 shows the terminal flag inhibit setting
// - bit 9 sets on word count fault, held until error clear
// - bit 8 sets on manchester fault, held until error clear
// - bit 7 sets on parity fault, held until error clear
// - bit 5 sets on backend timeout, cleared by error clear; bit 6 zero
// - bits 4 to 0 carry the core version code
// - the BIT word is handed to the bus controller path
// - vector bit 11 high when terminal address is 31 (broadcast)
// - vector bit 10 is the transmit/receive bit
// - vector bits 9 to 5 are the sub-address
// - vector carries word count, a mode code for sub-address 0 or 31
// - legality judged internally or by outside logic from vector fields
// - illegal command: message error flag, status sent, failure interrupt
// ----------------------------------------
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module rbt_bit_core #(
  parameter int OVERRUN_CYC = rbt_pkg::OVERRUN_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_bit_cmd,
  input  wire logic        i_bit_cmd_bus,
  input  wire logic [1:0]  i_loopback_fault,
  input  wire logic        i_word_count_fault,
  input  wire logic        i_manchester_fault,
  input  wire logic        i_parity_fault,
  input  wire logic        i_backend_timeout_fault,
  input  wire logic        i_error_clear_in,
  input  wire logic [1:0]  i_tx_active,
  input  wire logic [1:0]  i_shutdown_mc,
  input  wire logic [1:0]  i_reenable_mc,
  input  wire logic        i_cmd_stb,
  input  wire logic [15:0] i_cmd_word,
  input  wire logic        i_command_accepted,
  output logic      [11:0] o_command_vector,
  output logic      [15:0] o_bit_word,
  output logic      [1:0]  o_bus_disabled,
  output logic             o_message_error_flag,
  output logic             o_status_tx_req,
  output logic             o_msg_fail_irq
);
  // ----------------------------------------
  // error clear pin synchroniser
  // ----------------------------------------
  logic clr_s1_r;
  logic clr_s2_r;
  logic clr_s3_r;
  logic clr_lvl_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clr_s1_r  <= 1'b0;
      clr_s2_r  <= 1'b0;
      clr_s3_r  <= 1'b0;
      clr_lvl_r <= 1'b0;
    end else if (i_ce) begin
      clr_s1_r <= i_error_clear_in;
      clr_s2_r <= clr_s1_r;
      clr_s3_r <= clr_s2_r;
      // a change counts only once two stages agree
      if (clr_s2_r == clr_s3_r) clr_lvl_r <= clr_s3_r;
    end
  end

  // ----------------------------------------
  // register port decode
  // ----------------------------------------
  logic [1:0] ctrl_r;
  wire        wr_ctrl  = i_wr && (i_addr == rbt_pkg::REG_CTRL);
  wire        soft_clr = wr_ctrl && i_wdata[rbt_pkg::CTRL_CLR];
  wire        err_clr  = clr_lvl_r || soft_clr;
  wire        tfi      = ctrl_r[rbt_pkg::CTRL_TFI];
  wire        ext_en   = ctrl_r[rbt_pkg::CTRL_EXT];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_r <= rbt_pkg::CTRL_RST;
    end else if (i_ce && wr_ctrl) begin
      ctrl_r <= i_wdata[1:0];
    end
  end

  // ----------------------------------------
  // sticky fault bits
  // ----------------------------------------
  // order: loopback A, loopback B, word count, manchester, parity, backend
  localparam int NF = 6;
  logic [NF-1:0] flt_r;
  wire  [NF-1:0] flt_evt = {i_backend_timeout_fault, i_parity_fault,
                            i_manchester_fault, i_word_count_fault,
                            i_loopback_fault};

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_flt
      // a fault arriving with the clear survives it
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          flt_r[gi] <= 1'b0;
        end else if (i_ce) begin
          if (flt_evt[gi]) flt_r[gi] <= 1'b1;
          else if (err_clr) flt_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // bus shutdown per bus
  // ----------------------------------------
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bus
      rbt_overrun_timer #(
        .LIMIT (OVERRUN_CYC)
      ) u_ovr (
        .i_clk         (i_clk),
        .i_srst        (i_srst),
        .i_ce          (i_ce),
        .i_tx_active   (i_tx_active[gi]),
        .i_shutdown_mc (i_shutdown_mc[gi]),
        .i_reenable_mc (i_reenable_mc[gi]),
        .o_disabled    (o_bus_disabled[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // built-in-test word
  // ----------------------------------------
  logic bus_sel_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bus_sel_r <= 1'b0;
    end else if (i_ce && i_bit_cmd) begin
      bus_sel_r <= i_bit_cmd_bus;
    end
  end

  wire [15:0] bit_nxt = {bus_sel_r,
                         flt_r[1],
                         flt_r[0],
                         o_bus_disabled[1],
                         o_bus_disabled[0],
                         tfi,
                         flt_r[2],
                         flt_r[3],
                         flt_r[4],
                         1'b0,
                         flt_r[5],
                         rbt_pkg::CORE_VERSION};

  // registered copy feeds the transmit path toward the bus controller
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_bit_word <= rbt_pkg::BIT_RST;
    end else if (i_ce) begin
      o_bit_word <= bit_nxt;
    end
  end

  // ----------------------------------------
  // command legality
  // ----------------------------------------
  logic lg_busy;
  logic lg_done;
  logic lg_legal;

  rbt_cmd_legality u_leg (
    .i_clk              (i_clk),
    .i_srst             (i_srst),
    .i_ce               (i_ce),
    .i_cmd_stb          (i_cmd_stb),
    .i_cmd_word         (i_cmd_word),
    .i_ext_en           (ext_en),
    .i_command_accepted (i_command_accepted),
    .o_command_vector   (o_command_vector),
    .o_busy             (lg_busy),
    .o_done             (lg_done),
    .o_legal            (lg_legal)
  );

  wire illegal = lg_done && !lg_legal;

  // the flag lasts until the next command; a verdict beats a new strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_message_error_flag <= 1'b0;
      o_status_tx_req      <= 1'b0;
      o_msg_fail_irq       <= 1'b0;
    end else if (i_ce) begin
      o_status_tx_req <= illegal;
      o_msg_fail_irq  <= illegal;
      if (illegal) o_message_error_flag <= 1'b1;
      else if (i_cmd_stb) o_message_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // read data, valid only in the cycle after the strobe
  // ----------------------------------------
  wire [31:0] cmd_view = {17'h00000, lg_busy, o_message_error_flag,
                          lg_legal, o_command_vector};
  wire [31:0] rd_mux   = (i_addr == rbt_pkg::REG_BIT)  ? {16'h0000, o_bit_word} :
                         (i_addr == rbt_pkg::REG_CTRL) ? {30'h00000000, ctrl_r} :
                         (i_addr == rbt_pkg::REG_CMD)  ? cmd_view :
                         32'h00000000;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  AST_BUS_SEL: assert property (
    (i_ce && i_bit_cmd) ##1 i_ce |=> o_bit_word[15] == $past(i_bit_cmd_bus, 2))
    else $error("bus select bit wrong");
  AST_LPBK_B: assert property (
    (i_ce && i_loopback_fault[1]) ##1 i_ce |=> o_bit_word[14])
    else $error("bus B loopback bit not set");
  AST_LPBK_A: assert property (
    (i_ce && i_loopback_fault[0]) ##1 i_ce |=> o_bit_word[13])
    else $error("bus A loopback bit not set");
  AST_DIS_A: assert property (
    (i_ce && i_shutdown_mc[0]) ##1 i_ce |=> o_bit_word[11])
    else $error("bus A shutdown not shown");
  AST_TFI: assert property (
    i_ce |=> o_bit_word[10] == $past(tfi))
    else $error("flag inhibit bit mismatch");
  AST_WC: assert property (
    (i_ce && i_word_count_fault) ##1 i_ce |=> o_bit_word[9])
    else $error("word count bit not set");
  AST_MAN: assert property (
    (i_ce && i_manchester_fault) ##1 i_ce |=> o_bit_word[8])
    else $error("manchester bit not set");
  AST_PAR: assert property (
    (i_ce && i_parity_fault) ##1 i_ce |=> o_bit_word[7])
    else $error("parity bit not set");
  AST_MEM_RSV: assert property (
    ((i_ce && i_backend_timeout_fault) ##1 i_ce |=> o_bit_word[5])
    and (1'b1 |-> !o_bit_word[6]))
    else $error("backend bit or reserved bit wrong");
  AST_VERSION: assert property (
    o_bit_word[4:0] == rbt_pkg::CORE_VERSION)
    else $error("version field wrong");
  AST_RD_BIT: assert property (
    (i_ce && i_rd && i_addr == rbt_pkg::REG_BIT) |=> o_rdata[15:0] == $past(o_bit_word))
    else $error("BIT word read back wrong");
  AST_STICKY: assert property (
    $fell(flt_r[2]) |-> $past(err_clr) && !$past(flt_evt[2]))
    else $error("fault bit dropped without clear");
  AST_ILLEGAL: assert property (
    (i_ce && illegal) |=> o_message_error_flag && o_status_tx_req && o_msg_fail_irq)
    else $error("illegal command not flagged");
  AST_DIS_B: assert property (
    (i_ce && i_shutdown_mc[1]) ##1 i_ce |=> o_bit_word[12])
    else $error("bus B shutdown not shown");
  AST_CLR_ALL: assert property (
    (i_ce && err_clr && flt_evt == '0) |=> flt_r == '0)
    else $error("error clear left a fault bit set");
  AST_VEC_BCAST: assert property (
    (i_ce && i_cmd_stb && !lg_busy) |=>
      o_command_vector[rbt_pkg::CV_BCAST] == ($past(i_cmd_word[15:11]) == rbt_pkg::BCAST_ADDR))
    else $error("broadcast bit of command vector wrong");
  AST_VEC_TX: assert property (
    (i_ce && i_cmd_stb && !lg_busy) |=>
      o_command_vector[rbt_pkg::CV_TX] == $past(i_cmd_word[rbt_pkg::CW_TX]))
    else $error("transmit bit of command vector wrong");
  AST_VEC_WC: assert property (
    (i_ce && i_cmd_stb && !lg_busy) |=> o_command_vector[4:0] == $past(i_cmd_word[4:0]))
    else $error("word count field of command vector wrong");
  AST_RD_CMD: assert property (
    (i_ce && i_rd && i_addr == rbt_pkg::REG_CMD) |=> o_rdata[11:0] == $past(o_command_vector))
    else $error("command vector read back wrong");
  AST_STATUS_PULSE: assert property (
    (i_ce && o_status_tx_req) |=> !o_status_tx_req)
    else $error("status request longer than one cycle");
endmodule

// file: src/rbt_cmd_legality.sv
// command vector build and legality handshake
module rbt_cmd_legality (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic        i_cmd_stb,
  input  wire logic [15:0] i_cmd_word,
  input  wire logic        i_ext_en,
  input  wire logic        i_command_accepted,
  output logic      [11:0] o_command_vector,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_legal
);
  typedef enum logic {RBT_IDLE, RBT_WAIT} rbt_lstate_t;

  localparam logic [8:0] WAIT_LAST = 9'(rbt_pkg::LEGAL_WAIT_CYC - 1);

  rbt_lstate_t st_r;
  logic [8:0]  wait_r;

  wire [4:0]  rta   = i_cmd_word[rbt_pkg::CW_RTA_LSB +: 5];
  wire [11:0] vec_nxt = {rta == rbt_pkg::BCAST_ADDR,
                         i_cmd_word[rbt_pkg::CW_TX],
                         i_cmd_word[rbt_pkg::CW_SA_LSB +: 5],
                         i_cmd_word[4:0]};
  // internal judge: a broadcast transmit is never legal
  wire int_ok  = !(o_command_vector[rbt_pkg::CV_BCAST]
                   && o_command_vector[rbt_pkg::CV_TX]);
  wire timeout = (wait_r == WAIT_LAST);
  wire decide  = (st_r == RBT_WAIT) && (!i_ext_en || i_command_accepted || timeout);
  wire ok_nxt  = i_ext_en ? i_command_accepted : int_ok;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r             <= RBT_IDLE;
      wait_r           <= '0;
      o_command_vector <= '0;
      o_done           <= 1'b0;
      o_legal          <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      case (st_r)
        RBT_IDLE: begin
          wait_r <= '0;
          if (i_cmd_stb) begin
            o_command_vector <= vec_nxt;
            st_r             <= RBT_WAIT;
          end
        end
        RBT_WAIT: begin
          wait_r <= wait_r + 1'b1;
          if (decide) begin
            o_done  <= 1'b1;
            o_legal <= ok_nxt;
            st_r    <= RBT_IDLE;
          end
        end
        default: st_r <= RBT_IDLE;
      endcase
    end
  end

  assign o_busy = (st_r == RBT_WAIT);

  AST_VEC_FIELDS: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_ce && i_cmd_stb && st_r == RBT_IDLE) |=>
      o_command_vector == {$past(i_cmd_word[15:11]) == 5'h1F, $past(i_cmd_word[10:0])})
    else $error("command vector fields wrong");
  AST_DECIDE_BOUND: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r == RBT_WAIT) |-> (wait_r <= WAIT_LAST))
    else $error("legality wait overran 3 us");
endmodule

// file: src/rbt_overrun_timer.sv
// per-bus transmitter overrun timer and shutdown flag
module rbt_overrun_timer #(
  parameter int LIMIT = rbt_pkg::OVERRUN_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_tx_active,
  input  wire logic i_shutdown_mc,
  input  wire logic i_reenable_mc,
  output logic      o_disabled
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_r;
  wire           at_lim  = (cnt_r == LIM);
  wire           overrun = at_lim && i_tx_active;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= '0;
    end else if (i_ce) begin
      if (!i_tx_active) cnt_r <= '0;
      else if (!at_lim) cnt_r <= cnt_r + 1'b1;
    end
  end

  // shutdown beats re-enable if both land together
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_disabled <= 1'b0;
    end else if (i_ce) begin
      if (overrun || i_shutdown_mc) o_disabled <= 1'b1;
      else if (i_reenable_mc) o_disabled <= 1'b0;
    end
  end

  AST_OVR_SHUT: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_ce && i_tx_active && cnt_r == LIM) |=> o_disabled)
    else $error("transmitter overrun did not disable bus");
endmodule

// file: src/rbt_pkg.sv
// shared constants for the rt built-in test and command legality block
package rbt_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int LEGAL_WAIT_NS  = 3000;
  // longest time: rounds down
  localparam int LEGAL_WAIT_CYC = (LEGAL_WAIT_NS * CLK_MHZ) / 1000;
  localparam int OVERRUN_US     = 668;
  localparam int OVERRUN_CYC    = OVERRUN_US * CLK_MHZ;

  // ----------------------------------------
  // built-in-test word layout
  // ----------------------------------------
  localparam int BIT_BUS_SEL = 15;
  localparam int BIT_LPBK_B  = 14;
  localparam int BIT_LPBK_A  = 13;
  localparam int BIT_DIS_B   = 12;
  localparam int BIT_DIS_A   = 11;
  localparam int BIT_TFI     = 10;
  localparam int BIT_WC      = 9;
  localparam int BIT_MAN     = 8;
  localparam int BIT_PAR     = 7;
  localparam int BIT_RSV     = 6;
  localparam int BIT_MEM     = 5;
  // arbitrary value
  localparam logic [4:0] CORE_VERSION = 5'h03;
  localparam logic [15:0] BIT_RST     = {11'h000, CORE_VERSION};

  // ----------------------------------------
  // command word and command vector layout
  // ----------------------------------------
  localparam int CW_RTA_LSB = 11;
  localparam int CW_TX      = 10;
  localparam int CW_SA_LSB  = 5;
  localparam int CV_BCAST   = 11;
  localparam int CV_TX      = 10;
  localparam int CV_SA_LSB  = 5;
  localparam logic [4:0] BCAST_ADDR = 5'h1F;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0]  REG_BIT   = 4'h0;
  localparam logic [3:0]  REG_CTRL  = 4'h4;
  localparam logic [3:0]  REG_CMD   = 4'h8;
  localparam int          CTRL_TFI  = 0;
  localparam int          CTRL_EXT  = 1;
  localparam int          CTRL_CLR  = 2;
  localparam logic [1:0]  CTRL_RST  = 2'h2;
  localparam int          CMD_LEGAL = 12;
  localparam int          CMD_MERR  = 13;
  localparam int          CMD_BUSY  = 14;
endpackage
